/* rtl/xema_top.sv */
// external data space access controller with AHB-Lite register slave
// assumes a single master doing single word transfers; one clock domain
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`include "xema_defines.svh"

// Notes on behaviour
// - short form: high byte from page select, low byte from chosen index
// - long form: full 16-bit address taken from the data pointer
// - data pointer read and written as high and low byte registers
// - on-chip RAM of 4k or 2k bytes sits in the space by default
// - with FIFO mapping on, 0x0400 to 0x07FF go to FIFO RAM
// - with FIFO mapping on, other memory at those addresses is hidden
// - FIFO accesses take more core clock cycles than on-chip RAM accesses
// - port pins are claimed only during an off-chip move, then released
// - drivers are off on pins acting as inputs during off-chip moves
// - push-pull or open-drain setting is never touched by this block
// - address, data and control go out on ports four to one
// - bus style selectable: multiplexed or separate address and data
// - four memory modes decide where each address is serviced
module xema_top #(
    parameter int RAM_BYTES = 4096
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic ext_claim,
    output logic [7:0] port4_data_o,
    output logic port4_data_oe,
    input wire logic [7:0] port4_data_i,
    output logic [7:0] port3_addr_lo_o,
    output logic port3_addr_lo_oe,
    output logic [7:0] port2_addr_hi_o,
    output logic port2_addr_hi_oe,
    output logic port1_wr_n_o,
    output logic port1_rd_n_o,
    output logic port1_ale_o,
    output logic port1_ctrl_oe
);
    import xema_pkg::*;

    localparam int RAM_AW = $clog2(RAM_BYTES);

    generate
        if (RAM_BYTES != 4096 && RAM_BYTES != 2048) begin : g_bad_size
            $error("RAM_BYTES must be 4096 or 2048");
        end
    endgenerate

    typedef enum logic [1:0] {
        XEMA_S_IDLE = 2'b00,
        XEMA_S_ONCHIP = 2'b01,
        XEMA_S_FIFO = 2'b10,
        XEMA_S_OFFCHIP = 2'b11
    } xema_state_e;

    xema_bus_if bus ();

    // registers seen by software
    xema_byte_t page_sel_r;
    xema_byte_t dp_high_r;
    xema_byte_t dp_low_r;
    xema_byte_t config_r;
    xema_byte_t index0_r;
    xema_byte_t index1_r;
    xema_byte_t rdata_r;
    xema_target_e target_r;

    // bus slave state
    logic wr_pend_r;
    logic rd_pend_r;
    logic [7:0] addr_r;
    logic hreadyout_r;
    logic hresp_r;
    logic [31:0] hrdata_r;

    // move engine state
    xema_state_e state_r;
    logic [3:0] wait_r;
    logic mv_we_r;
    logic [7:0] mv_wdata_r;
    xema_addr_t mv_addr_r;
    logic req_r;
    logic drive_hi_r;

    logic [7:0] ram_mem [RAM_BYTES];
    logic [7:0] fifo_mem [`XEMA_FIFO_BYTES];

    logic accept;
    logic cmd_wr;
    logic busy;
    xema_addr_t eff_addr;
    logic cmd_long;
    logic in_fifo;
    logic below_ram;
    xema_mode_e mode;

    assign busy = (state_r != XEMA_S_IDLE);
    assign accept = hsel && hready && htrans[1];
    assign cmd_wr = wr_pend_r && (addr_r == `XEMA_OFF_CMD) && !busy;
    assign cmd_long = hwdata[`XEMA_CMD_LONG];
    assign mode = xema_mode_e'(config_r[`XEMA_CFG_MODE_HI:`XEMA_CFG_MODE_LO]);

    // effective address of a new move
    always_comb begin
        if (cmd_long) begin
            eff_addr = {dp_high_r, dp_low_r};
        end else if (hwdata[`XEMA_CMD_INDEX]) begin
            eff_addr = {page_sel_r, index1_r};
        end else begin
            eff_addr = {page_sel_r, index0_r};
        end
    end

    assign in_fifo = config_r[`XEMA_CFG_MAP_EN] && (eff_addr >= `XEMA_FIFO_BASE)
        && (eff_addr <= `XEMA_FIFO_LAST);
    assign below_ram = (eff_addr < 16'(RAM_BYTES));

    // AHB-Lite address phase capture; writes land in the data phase
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            wr_pend_r <= accept && hwrite;
            rd_pend_r <= accept && !hwrite;
            if (accept) begin
                addr_r <= haddr[7:0];
            end
        end
    end

    // one wait state on reads since hrdata is registered a cycle after the address phase
    always_ff @(posedge clk) begin
        if (rst) begin
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            hreadyout_r <= !(accept && !hwrite);
            hresp_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata_r <= 32'h0000_0000;
        end else if (rd_pend_r) begin
            unique case (addr_r)
                `XEMA_OFF_PAGE_SEL: hrdata_r <= {24'h00_0000, page_sel_r};
                `XEMA_OFF_DP_HIGH: hrdata_r <= {24'h00_0000, dp_high_r};
                `XEMA_OFF_DP_LOW: hrdata_r <= {24'h00_0000, dp_low_r};
                `XEMA_OFF_CONFIG: hrdata_r <= {24'h00_0000, config_r};
                `XEMA_OFF_INDEX0: hrdata_r <= {24'h00_0000, index0_r};
                `XEMA_OFF_INDEX1: hrdata_r <= {24'h00_0000, index1_r};
                `XEMA_OFF_STATUS: hrdata_r <= {16'h0000, rdata_r, 5'h00, target_r, busy};
                default: hrdata_r <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            page_sel_r <= `XEMA_RST_PAGE_SEL;
            dp_high_r <= 8'h00;
            dp_low_r <= 8'h00;
            config_r <= `XEMA_RST_CONFIG;
            index0_r <= 8'h00;
            index1_r <= 8'h00;
        end else if (wr_pend_r) begin
            unique case (addr_r)
                `XEMA_OFF_PAGE_SEL: page_sel_r <= hwdata[7:0];
                `XEMA_OFF_DP_HIGH: dp_high_r <= hwdata[7:0];
                `XEMA_OFF_DP_LOW: dp_low_r <= hwdata[7:0];
                `XEMA_OFF_CONFIG: config_r <= hwdata[7:0] & `XEMA_CONFIG_MASK;
                `XEMA_OFF_INDEX0: index0_r <= hwdata[7:0];
                `XEMA_OFF_INDEX1: index1_r <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    // move sequencer; a command written while busy is dropped
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= XEMA_S_IDLE;
            wait_r <= 4'h0;
            mv_we_r <= 1'b0;
            mv_wdata_r <= 8'h00;
            mv_addr_r <= 16'h0000;
            req_r <= 1'b0;
            drive_hi_r <= 1'b0;
            target_r <= XEMA_TGT_ONCHIP;
        end else begin
            req_r <= 1'b0;
            unique case (state_r)
                XEMA_S_IDLE: begin
                    if (cmd_wr) begin
                        mv_we_r <= hwdata[`XEMA_CMD_WRITE];
                        mv_wdata_r <= hwdata[`XEMA_CMD_DATA_HI:`XEMA_CMD_DATA_LO];
                        mv_addr_r <= eff_addr;
                        // bank select in every mode but split-without-bank, and always in long form
                        drive_hi_r <= cmd_long || (mode != XEMA_SPLIT_NO_BANK);
                        if (in_fifo) begin
                            target_r <= XEMA_TGT_FIFO;
                            wait_r <= `XEMA_FIFO_WAIT;
                            state_r <= XEMA_S_FIFO;
                        end else if (mode == XEMA_ON_CHIP_ONLY
                                     || (mode != XEMA_OFF_CHIP_ONLY && below_ram)) begin
                            target_r <= XEMA_TGT_ONCHIP;
                            state_r <= XEMA_S_ONCHIP;
                        end else begin
                            target_r <= XEMA_TGT_OFFCHIP;
                            req_r <= 1'b1;
                            state_r <= XEMA_S_OFFCHIP;
                        end
                    end
                end
                XEMA_S_ONCHIP: begin
                    state_r <= XEMA_S_IDLE;
                end
                XEMA_S_FIFO: begin
                    // extra cycles cover the crossing into the USB domain
                    if (wait_r == 4'h0) begin
                        state_r <= XEMA_S_IDLE;
                    end else begin
                        wait_r <= wait_r - 4'h1;
                    end
                end
                XEMA_S_OFFCHIP: begin
                    if (bus.done) begin
                        state_r <= XEMA_S_IDLE;
                    end
                end
            endcase
        end
    end

    // on-chip and FIFO storage; on-chip only mode wraps the address
    always_ff @(posedge clk) begin
        if (state_r == XEMA_S_ONCHIP && mv_we_r) begin
            ram_mem[mv_addr_r[RAM_AW-1:0]] <= mv_wdata_r;
        end
        if (state_r == XEMA_S_FIFO && wait_r == 4'h0 && mv_we_r) begin
            fifo_mem[mv_addr_r[`XEMA_FIFO_AW-1:0]] <= mv_wdata_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (!mv_we_r) begin
            if (state_r == XEMA_S_ONCHIP) begin
                rdata_r <= ram_mem[mv_addr_r[RAM_AW-1:0]];
            end else if (state_r == XEMA_S_FIFO && wait_r == 4'h0) begin
                rdata_r <= fifo_mem[mv_addr_r[`XEMA_FIFO_AW-1:0]];
            end else if (state_r == XEMA_S_OFFCHIP && bus.done) begin
                rdata_r <= bus.rdata;
            end
        end
    end

    assign bus.req = req_r;
    assign bus.we = mv_we_r;
    assign bus.addr = mv_addr_r;
    assign bus.wdata = mv_wdata_r;
    assign bus.drive_hi = drive_hi_r;
    assign bus.muxed = !config_r[`XEMA_CFG_NONMUX];
    assign bus.ale_ext = config_r[`XEMA_CFG_ALE_HI:`XEMA_CFG_ALE_LO];

    // only enables are driven here; the port output mode stays elsewhere
    xema_offchip_engine u_engine (
        .clk(clk),
        .rst(rst),
        .bus(bus.engine),
        .claim(ext_claim),
        .data_o(port4_data_o),
        .data_oe(port4_data_oe),
        .data_i(port4_data_i),
        .addr_lo_o(port3_addr_lo_o),
        .addr_lo_oe(port3_addr_lo_oe),
        .addr_hi_o(port2_addr_hi_o),
        .addr_hi_oe(port2_addr_hi_oe),
        .wr_n_o(port1_wr_n_o),
        .rd_n_o(port1_rd_n_o),
        .ale_o(port1_ale_o),
        .ctrl_oe(port1_ctrl_oe)
    );

    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign hrdata = hrdata_r;
endmodule

/* rtl/xema_defines.svh */
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the modules that need these figures
`ifndef XEMA_DEFINES_SVH
`define XEMA_DEFINES_SVH

`define XEMA_OFF_PAGE_SEL 8'h00
`define XEMA_OFF_DP_HIGH 8'h04
`define XEMA_OFF_DP_LOW 8'h08
`define XEMA_OFF_CONFIG 8'h0C
`define XEMA_OFF_INDEX0 8'h10
`define XEMA_OFF_INDEX1 8'h14
`define XEMA_OFF_CMD 8'h18
`define XEMA_OFF_STATUS 8'h1C

`define XEMA_RST_PAGE_SEL 8'h00
`define XEMA_RST_CONFIG 8'h03
`define XEMA_CONFIG_MASK 8'h5F

`define XEMA_CFG_MAP_EN 6
`define XEMA_CFG_NONMUX 4
`define XEMA_CFG_MODE_HI 3
`define XEMA_CFG_MODE_LO 2
`define XEMA_CFG_ALE_HI 1
`define XEMA_CFG_ALE_LO 0

`define XEMA_CMD_WRITE 0
`define XEMA_CMD_LONG 1
`define XEMA_CMD_INDEX 2
`define XEMA_CMD_DATA_HI 15
`define XEMA_CMD_DATA_LO 8

`define XEMA_STS_BUSY 0
`define XEMA_STS_TGT_LO 1
`define XEMA_STS_TGT_HI 2

`define XEMA_FIFO_BASE 16'h0400
`define XEMA_FIFO_LAST 16'h07FF
`define XEMA_FIFO_AW 10
`define XEMA_FIFO_BYTES 1024

`define XEMA_FIFO_WAIT 4'h3
`define XEMA_SETUP_CYC 4'h1
`define XEMA_STROBE_CYC 4'h2
`define XEMA_HOLD_CYC 4'h1

`endif

/* rtl/xema_pkg.sv */
// types shared by the memory access controller and its off-chip bus engine
// assumes xema_defines.svh holds the numeric figures
package xema_pkg;
    typedef enum logic [1:0] {
        XEMA_ON_CHIP_ONLY = 2'b00,
        XEMA_SPLIT_NO_BANK = 2'b01,
        XEMA_SPLIT_BANK = 2'b10,
        XEMA_OFF_CHIP_ONLY = 2'b11
    } xema_mode_e;

    typedef enum logic [1:0] {
        XEMA_TGT_ONCHIP = 2'b00,
        XEMA_TGT_FIFO = 2'b01,
        XEMA_TGT_OFFCHIP = 2'b10
    } xema_target_e;

    typedef logic [7:0] xema_byte_t;
    typedef logic [15:0] xema_addr_t;
endpackage

/* rtl/xema_bus_if.sv */
// request and answer between the access controller and the off-chip engine
// assumes one clock for both ends; req is a one-cycle pulse, done likewise
interface xema_bus_if;
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic drive_hi;
    logic muxed;
    logic [1:0] ale_ext;
    logic done;
    logic [7:0] rdata;

    modport ctrl (output req, we, addr, wdata, drive_hi, muxed, ale_ext, input done, rdata);
    modport engine (input req, we, addr, wdata, drive_hi, muxed, ale_ext, output done, rdata);
endinterface

/* rtl/xema_offchip_engine.sv */
// off-chip bus engine: claims the port pins for one access and parks them again
// assumes one access at a time; ctrl waits for done before the next req
`include "xema_defines.svh"

module xema_offchip_engine (
    input wire logic clk,
    input wire logic rst,
    xema_bus_if.engine bus,
    output logic claim,
    output logic [7:0] data_o,
    output logic data_oe,
    input wire logic [7:0] data_i,
    output logic [7:0] addr_lo_o,
    output logic addr_lo_oe,
    output logic [7:0] addr_hi_o,
    output logic addr_hi_oe,
    output logic wr_n_o,
    output logic rd_n_o,
    output logic ale_o,
    output logic ctrl_oe
);
    import xema_pkg::*;

    typedef enum logic [2:0] {
        XEMA_E_IDLE = 3'b000,
        XEMA_E_ALE = 3'b001,
        XEMA_E_SETUP = 3'b010,
        XEMA_E_STROBE = 3'b011,
        XEMA_E_HOLD = 3'b100
    } xema_eng_e;

    xema_eng_e state_r;
    logic [3:0] cnt_r;
    logic we_r;
    logic muxed_r;
    logic [7:0] wdata_r;
    logic [7:0] lo_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= XEMA_E_IDLE;
            cnt_r <= 4'h0;
            we_r <= 1'b0;
            muxed_r <= 1'b0;
            wdata_r <= 8'h00;
            lo_r <= 8'h00;
            bus.done <= 1'b0;
            bus.rdata <= 8'h00;
            claim <= 1'b0;
            data_o <= 8'h00;
            data_oe <= 1'b0;
            addr_lo_o <= 8'h00;
            addr_lo_oe <= 1'b0;
            addr_hi_o <= 8'h00;
            addr_hi_oe <= 1'b0;
            wr_n_o <= 1'b1;
            rd_n_o <= 1'b1;
            ale_o <= 1'b0;
            ctrl_oe <= 1'b0;
        end else begin
            bus.done <= 1'b0;
            unique case (state_r)
                XEMA_E_IDLE: begin
                    if (bus.req) begin
                        we_r <= bus.we;
                        muxed_r <= bus.muxed;
                        wdata_r <= bus.wdata;
                        lo_r <= bus.addr[7:0];
                        claim <= 1'b1;
                        ctrl_oe <= 1'b1;
                        addr_hi_o <= bus.addr[15:8];
                        addr_hi_oe <= bus.drive_hi;
                        if (bus.muxed) begin
                            data_o <= bus.addr[7:0];
                            data_oe <= 1'b1;
                            ale_o <= 1'b1;
                            cnt_r <= {2'b00, bus.ale_ext};
                            state_r <= XEMA_E_ALE;
                        end else begin
                            addr_lo_o <= bus.addr[7:0];
                            addr_lo_oe <= 1'b1;
                            data_o <= bus.wdata;
                            data_oe <= bus.we;
                            cnt_r <= `XEMA_SETUP_CYC - 4'h1;
                            state_r <= XEMA_E_SETUP;
                        end
                    end
                end
                XEMA_E_ALE: begin
                    if (cnt_r == 4'h0) begin
                        ale_o <= 1'b0;
                        data_o <= wdata_r;
                        data_oe <= we_r;
                        cnt_r <= `XEMA_SETUP_CYC - 4'h1;
                        state_r <= XEMA_E_SETUP;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                XEMA_E_SETUP: begin
                    if (cnt_r == 4'h0) begin
                        wr_n_o <= ~we_r;
                        rd_n_o <= we_r;
                        cnt_r <= `XEMA_STROBE_CYC - 4'h1;
                        state_r <= XEMA_E_STROBE;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                XEMA_E_STROBE: begin
                    if (cnt_r == 4'h0) begin
                        if (!we_r) begin
                            bus.rdata <= data_i;
                        end
                        wr_n_o <= 1'b1;
                        rd_n_o <= 1'b1;
                        cnt_r <= `XEMA_HOLD_CYC - 4'h1;
                        state_r <= XEMA_E_HOLD;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                XEMA_E_HOLD: begin
                    if (cnt_r == 4'h0) begin
                        // release every pin: the port latches take over again
                        claim <= 1'b0;
                        data_oe <= 1'b0;
                        addr_lo_oe <= 1'b0;
                        addr_hi_oe <= 1'b0;
                        ctrl_oe <= 1'b0;
                        bus.done <= 1'b1;
                        state_r <= XEMA_E_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                default: begin
                    state_r <= XEMA_E_IDLE;
                end
            endcase
        end
    end
endmodule

/* bench/xema_top_chk.sv */
// port-level assertions for the external data space access controller
// assumes one clock domain; hready is fed back from hreadyout by the bench
module xema_top_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic ext_claim,
    input wire logic port4_data_oe,
    input wire logic port3_addr_lo_oe,
    input wire logic port2_addr_hi_oe,
    input wire logic port1_wr_n_o,
    input wire logic port1_rd_n_o,
    input wire logic port1_ale_o,
    input wire logic port1_ctrl_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_resp_okay: assert property (hresp == 1'b0)
        else $error("slave answered other than okay");
    a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite
        |=> !hreadyout ##1 hreadyout) else $error("read wait state not one cycle");
    a_strobes_park: assert property (!ext_claim
        |-> port1_rd_n_o && port1_wr_n_o && !port1_ale_o) else $error("strobe while parked");
    a_pins_release: assert property (!ext_claim
        |-> !(port4_data_oe || port3_addr_lo_oe || port2_addr_hi_oe))
        else $error("pin driven outside a claim");
    a_ctrl_claim: assert property (port1_ctrl_oe == ext_claim)
        else $error("control enable differs from claim");
    a_read_no_drive: assert property (!port1_rd_n_o |-> !port4_data_oe)
        else $error("data driven during read strobe");
    a_write_drives: assert property (!port1_wr_n_o |-> port4_data_oe)
        else $error("data not driven during write strobe");
    a_strobe_width: assert property ($fell(port1_rd_n_o) |=>
        !port1_rd_n_o ##1 port1_rd_n_o) else $error("read strobe not two cycles");
    a_ale_muxed: assert property (port1_ale_o
        |-> port4_data_oe && !port3_addr_lo_oe) else $error("latch strobe off muxed bus");
    a_one_strobe: assert property (port1_rd_n_o || port1_wr_n_o)
        else $error("both strobes active");
endmodule

bind xema_top xema_top_chk chk_i (.clk, .rst, .hsel, .htrans, .hwrite, .hready, .hreadyout,
    .hresp, .ext_claim, .port4_data_oe, .port3_addr_lo_oe, .port2_addr_hi_oe,
    .port1_wr_n_o, .port1_rd_n_o, .port1_ale_o, .port1_ctrl_oe);

/* bench/xema_ext_mem.sv */
// off-chip byte memory answering the external interface pins
// assumes parked high-address pins read high through the port latch
module xema_ext_mem (
    input wire logic clk,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic ale,
    input wire logic [7:0] dq_o,
    output logic [7:0] dq_i,
    input wire logic [7:0] lo,
    input wire logic lo_oe,
    input wire logic [7:0] hi,
    input wire logic hi_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // strobe and latch pins reach this model directly, as if skipped by the crossbar
    logic [7:0] mem [0:65535];
    logic [7:0] lo_lat = 8'h00;
    logic [7:0] last = 8'h00;
    logic [15:0] a;
    // undriven high byte floats to the parked latch level
    assign a = {hi_oe ? hi : 8'hFF, lo_oe ? lo : lo_lat};
    // plain always: the bench presets locations of this array as well
    always @(posedge clk) begin
        if (ale)
            lo_lat <= dq_o;
        if (!wr_n)
            mem[a] <= dq_o;
        if (!rd_n)
            last <= mem[a];
    end
    // released bus shows the inverse so a stale value cannot pass
    assign dq_i = rd_n ? ~last : mem[a];
endmodule

/* bench/xema_external_memory_access_tb.sv */
// self-checking bench for the access controller over AHB-Lite
// assumes xema_ext_mem on the port pins and the checker bound in
module external_data_space_external_memory_access_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import xema_pkg::*;
`include "xema_defines.svh"
    logic clk = 0, rst = 1, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0;
    logic claim, d_oe, lo_oe, hi_oe, wr_n, rd_n, ale, c_oe;
    logic [7:0] d_o, d_i, lo, hi;
    int mismatches = 0, n_compared = 0, po, pf, p;
    logic [31:0] st;
    assign hready = hreadyout;
    xema_top DUT (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready, .hreadyout, .hresp, .hrdata, .ext_claim(claim), .port4_data_o(d_o),
        .port4_data_oe(d_oe), .port4_data_i(d_i), .port3_addr_lo_o(lo),
        .port3_addr_lo_oe(lo_oe), .port2_addr_hi_o(hi), .port2_addr_hi_oe(hi_oe),
        .port1_wr_n_o(wr_n), .port1_rd_n_o(rd_n), .port1_ale_o(ale), .port1_ctrl_oe(c_oe));
    xema_ext_mem mem_i (.clk, .rd_n, .wr_n, .ale, .dq_o(d_o), .dq_i(d_i), .lo, .lo_oe,
        .hi, .hi_oe);
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic tally_and_finish();
        if (mismatches == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // one move; long form through the data pointer, short form through index1
    task automatic mv(input logic [15:0] a, input logic w, input logic [7:0] d,
            input logic lng, output logic [31:0] s, output int n);
        logic [31:0] r;
        if (lng) begin
            ahb(1, `XEMA_OFF_DP_HIGH, {24'h0, a[15:8]}, r);
            ahb(1, `XEMA_OFF_DP_LOW, {24'h0, a[7:0]}, r);
        end else begin
            ahb(1, `XEMA_OFF_PAGE_SEL, {24'h0, a[15:8]}, r);
            ahb(1, `XEMA_OFF_INDEX1, {24'h0, a[7:0]}, r);
        end
        ahb(1, `XEMA_OFF_CMD, {16'h0, d, 5'h0, !lng, lng, w}, r);
        n = 0;
        s = 32'h1;
        while (s[0] !== 1'b0 && n < 60) begin
            ahb(0, `XEMA_OFF_STATUS, 32'h0, s);
            n++;
        end
        chk(s[0], 1'b0);
    endtask
    task automatic t_regs();
        logic [31:0] r;
        ahb(0, `XEMA_OFF_CONFIG, 0, r); chk(r, 32'h3);
        ahb(0, `XEMA_OFF_PAGE_SEL, 0, r); chk(r, 32'h0);
        ahb(1, `XEMA_OFF_CONFIG, 32'hFF, r);
        ahb(0, `XEMA_OFF_CONFIG, 0, r); chk(r, 32'h5F);
        ahb(1, `XEMA_OFF_DP_HIGH, 32'hA1, r);
        ahb(1, `XEMA_OFF_DP_LOW, 32'hB2, r);
        ahb(0, `XEMA_OFF_DP_HIGH, 0, r); chk(r, 32'hA1);
        ahb(0, `XEMA_OFF_DP_LOW, 0, r); chk(r, 32'hB2);
        ahb(1, 8'h20, 32'h55, r);
        ahb(0, 8'h20, 0, r); chk(r, 32'h0);
    endtask
    // every memory mode; the two split modes with a low and a high address, the others with one
    task automatic t_modes();
        logic [31:0] r;
        logic [7:0] cfg [6] = '{8'h10, 8'h14, 8'h14, 8'h18, 8'h18, 8'h1C};
        logic [15:0] ad [6] = '{16'h2000, 16'h0100, 16'h2000, 16'h0180, 16'h3000, 16'h0200};
        logic [1:0] tg [6] = '{XEMA_TGT_ONCHIP, XEMA_TGT_ONCHIP, XEMA_TGT_OFFCHIP,
            XEMA_TGT_ONCHIP, XEMA_TGT_OFFCHIP, XEMA_TGT_OFFCHIP};
        for (int i = 0; i < 6; i++) begin
            ahb(1, `XEMA_OFF_CONFIG, {24'h0, cfg[i]}, r);
            mv(ad[i], 1, 8'h30 + i, 1, st, p);
            chk(st[2:0], {tg[i], 1'b0});
            if (tg[i] == XEMA_TGT_OFFCHIP)
                chk(mem_i.mem[ad[i]], 8'h30 + i);
            mv(ad[i], 0, 8'h00, 1, st, p);
            chk(st[15:8], 8'h30 + i);
            if (i == 1)
                po = p;
        end
    endtask
    task automatic t_short();
        logic [31:0] r;
        ahb(1, `XEMA_OFF_CONFIG, 32'h1C, r);
        mv(16'h1234, 1, 8'h5A, 1, st, p);
        ahb(1, `XEMA_OFF_INDEX0, 32'h77, r);
        mv(16'h1234, 0, 8'h00, 0, st, p);
        chk(st[15:8], 8'h5A);
        // split without bank: short form leaves the high pins parked high
        ahb(1, `XEMA_OFF_CONFIG, 32'h14, r);
        mv(16'hFF34, 1, 8'hA5, 1, st, p);
        mv(16'h1234, 0, 8'h00, 0, st, p);
        chk(st[15:8], 8'hA5);
    endtask
    task automatic t_mux();
        logic [31:0] r;
        ahb(1, `XEMA_OFF_CONFIG, 32'h0D, r);
        mv(16'h2345, 1, 8'hC3, 1, st, p);
        chk(mem_i.mem[16'h2345], 8'hC3);
        mv(16'h2345, 0, 8'h00, 1, st, p);
        chk(st[15:8], 8'hC3);
    endtask
    task automatic t_fifo();
        logic [31:0] r;
        // bench clock stands in for a running, fast enough USB clock
        // 0x0500 is a spare FIFO location holding no packet data
        mem_i.mem[16'h0500] = 8'h11;
        ahb(1, `XEMA_OFF_CONFIG, 32'h5C, r);
        mv(16'h0500, 1, 8'h6E, 1, st, pf);
        chk(st[2:1], XEMA_TGT_FIFO);
        chk(pf > po, 1);
        chk(mem_i.mem[16'h0500], 8'h11);
        mv(16'h0500, 0, 8'h00, 1, st, p);
        chk(st[15:8], 8'h6E);
        ahb(1, `XEMA_OFF_CONFIG, 32'h1C, r);
        mv(16'h0500, 0, 8'h00, 1, st, p);
        chk(st[15:8], 8'h11);
    endtask
    initial begin
        #40000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_modes();
        t_short();
        t_mux();
        t_fifo();
        repeat (4) @(posedge clk);
        tally_and_finish();
    end
endmodule
